// [inc/adc_ctrl_pkg.sv]
// Overview of operation
// - writing start bit begins conversion, self-clears
// - mode 00 off, 01 single, 11 repeat
// - input gate bit enables analog inputs
// - four-bit field picks one of sixteen channels
// - low-power entry resets primary, keeps channel
// - low-power entry resets status, keeps time, deep-idle
// - deep idle stops converter unless control bit set
// - end flag cleared at start-bit launch, high after conversion, kept high over repeat restart
// - reading upper result clears end flag
// - busy high from start until finish
// - width bit: 0 ten-bit, 1 eight-bit storage
// - time code selects 78 to 1248 clocks
// - completion stores result, sets flag, raises interrupt
// - repeat mode restarts automatically after completion
// - mode 00 aborts at once, discards result
// - ten-bit mode: upper bits 7:2 read zero
`default_nettype none
package adc_ctrl_pkg;
  // printed offsets are register indexes; byte address is index * 4
  localparam logic [9:0] IDX_PRIMARY      = 10'h2B0;
  localparam logic [9:0] IDX_STATUS       = 10'h2B1;
  localparam logic [9:0] IDX_RESULT_LOWER = 10'h2B2;
  localparam logic [9:0] IDX_RESULT_UPPER = 10'h2B3;

  localparam int BIT_START      = 7;
  localparam int BIT_MODE_HI    = 6;
  localparam int BIT_MODE_LO    = 5;
  localparam int BIT_GATE       = 4;
  localparam int BIT_END        = 7;
  localparam int BIT_BUSY       = 6;
  localparam int BIT_WIDTH      = 5;
  localparam int BIT_DEEP_IDLE  = 4;

  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_REPEAT = 2'h3;

  localparam logic [3:0] TIME_RESET  = 4'hC;
  localparam logic [3:0] TIME_78     = 4'hA;
  localparam logic [3:0] TIME_156    = 4'hB;
  localparam logic [3:0] TIME_312    = 4'hC;
  localparam logic [3:0] TIME_624    = 4'hD;
  localparam logic [3:0] TIME_1248   = 4'hE;

  localparam logic [10:0] CYC_78   = 11'h04E;
  localparam logic [10:0] CYC_156  = 11'h09C;
  localparam logic [10:0] CYC_312  = 11'h138;
  localparam logic [10:0] CYC_624  = 11'h270;
  localparam logic [10:0] CYC_1248 = 11'h4E0;
endpackage
`default_nettype wire

// [rtl/conv_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module conv_timer (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        load,
  input  wire logic        abort,
  input  wire logic [10:0] length,
  output logic             expire
);
  logic [10:0] count;
  logic        running;
  logic [10:0] next_count;
  logic        next_running;

  assign expire = running && (count == 11'h000);

  always_comb begin
    next_count   = count;
    next_running = running;
    if (running && count != 11'h000) begin
      next_count = count - 11'h001;
    end
    if (expire) begin
      next_running = 1'b0;
    end
    if (load) begin
      next_count   = length - 11'h001;
      next_running = 1'b1;
    end
    if (abort) begin
      next_running = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count   <= 11'h000;
      running <= 1'b0;
    end else begin
      count   <= next_count;
      running <= next_running;
    end
  end
endmodule
`default_nettype wire

// [rtl/adc_control_registers.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_control_registers (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        enterStop,
  input  wire logic        enterSlow,
  input  wire logic        enterLightIdle,
  input  wire logic        inDeepIdle,
  input  wire logic [9:0]  convResult,
  output logic [3:0]       analogChannel,
  output logic             analogInputEnable,
  output logic             convRunning,
  output logic             convStart,
  output logic             convDoneIrq
);
  // bus data-phase state
  logic        dpWrite;
  logic [9:0]  dpIdx;
  logic        next_dpWrite;
  logic [9:0]  next_dpIdx;
  logic [31:0] next_hrdata;

  // control state
  logic       startBit;
  logic [1:0] opMode;
  logic       inputGate;
  logic [3:0] channel;
  logic       resultWidth;
  logic       deepIdleCtl;
  logic [3:0] convTime;
  logic       endFlag;
  logic       busy;
  logic [7:0] resUpper;
  logic [7:0] resLower;
  logic       irq;
  logic       startPulse;
  logic       next_startBit;
  logic [1:0] next_opMode;
  logic       next_inputGate;
  logic [3:0] next_channel;
  logic       next_resultWidth;
  logic       next_deepIdleCtl;
  logic [3:0] next_convTime;
  logic       next_endFlag;
  logic       next_busy;
  logic [7:0] next_resUpper;
  logic [7:0] next_resLower;
  logic       next_irq;
  logic       next_startPulse;

  logic        accept;
  logic        readUpperHit;
  logic        wrPrimary;
  logic        wrStatus;
  logic        lowPower;
  logic        deepHold;
  logic        abortNow;
  logic        launch;
  logic        expire;
  logic        done;
  logic [10:0] convLength;

  assign accept       = hsel && htrans[1] && hready;
  assign readUpperHit = accept && !hwrite
                        && haddr[11:2] == adc_ctrl_pkg::IDX_RESULT_UPPER;
  assign wrPrimary    = dpWrite && dpIdx == adc_ctrl_pkg::IDX_PRIMARY;
  assign wrStatus     = dpWrite && dpIdx == adc_ctrl_pkg::IDX_STATUS;
  assign lowPower     = enterStop || enterSlow || enterLightIdle;
  assign deepHold     = inDeepIdle && !deepIdleCtl;
  // a mode write of 00 kills the conversion in its own data phase
  assign abortNow     = lowPower || deepHold || (wrPrimary
    && hwdata[adc_ctrl_pkg::BIT_MODE_HI:adc_ctrl_pkg::BIT_MODE_LO]
       == adc_ctrl_pkg::MODE_OFF);
  assign done         = expire && busy && !abortNow;
  assign launch       = !abortNow && ((startBit && !busy
    && (opMode == adc_ctrl_pkg::MODE_SINGLE
        || opMode == adc_ctrl_pkg::MODE_REPEAT))
    || (done && opMode == adc_ctrl_pkg::MODE_REPEAT));

  // reserved codes fall back to the longest time, the safe side
  always_comb begin
    case (convTime)
      adc_ctrl_pkg::TIME_78:  convLength = adc_ctrl_pkg::CYC_78;
      adc_ctrl_pkg::TIME_156: convLength = adc_ctrl_pkg::CYC_156;
      adc_ctrl_pkg::TIME_312: convLength = adc_ctrl_pkg::CYC_312;
      adc_ctrl_pkg::TIME_624: convLength = adc_ctrl_pkg::CYC_624;
      default:                convLength = adc_ctrl_pkg::CYC_1248;
    endcase
  end

  conv_timer timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (launch),
    .abort   (abortNow),
    .length  (convLength),
    .expire  (expire)
  );

  always_comb begin
    next_dpWrite = accept && hwrite;
    next_dpIdx   = haddr[11:2];
    next_hrdata  = 32'h0000_0000;
    if (accept && !hwrite) begin
      if (haddr[11:2] == adc_ctrl_pkg::IDX_PRIMARY) begin
        next_hrdata[7:0] = {startBit, opMode, inputGate, channel};
      end else if (haddr[11:2] == adc_ctrl_pkg::IDX_STATUS) begin
        next_hrdata[7:0] = {endFlag, busy, resultWidth, deepIdleCtl,
                            convTime};
      end else if (haddr[11:2] == adc_ctrl_pkg::IDX_RESULT_LOWER) begin
        next_hrdata[7:0] = resLower;
      end else if (haddr[11:2] == adc_ctrl_pkg::IDX_RESULT_UPPER) begin
        next_hrdata[7:0] = resUpper;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dpWrite   <= 1'b0;
      dpIdx     <= 10'h000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dpWrite   <= next_dpWrite;
      dpIdx     <= next_dpIdx;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_comb begin
    next_startBit    = startBit;
    next_opMode      = opMode;
    next_inputGate   = inputGate;
    next_channel     = channel;
    next_resultWidth = resultWidth;
    next_deepIdleCtl = deepIdleCtl;
    next_convTime    = convTime;
    next_endFlag     = endFlag;
    next_busy        = busy;
    next_resUpper    = resUpper;
    next_resLower    = resLower;
    next_irq         = 1'b0;
    next_startPulse  = 1'b0;
    if (readUpperHit) begin
      next_endFlag = 1'b0;
    end
    if (done) begin
      next_endFlag = 1'b1;
      next_irq     = 1'b1;
      next_busy    = 1'b0;
      if (resultWidth) begin
        next_resUpper = convResult[9:2];
        next_resLower = convResult[7:0];
      end else begin
        next_resUpper = {6'h00, convResult[9:8]};
        next_resLower = convResult[7:0];
      end
    end
    if (startBit && !busy) begin
      next_startBit = 1'b0;
    end
    if (launch) begin
      next_busy       = 1'b1;
      next_startPulse = 1'b1;
      if (!done) begin
        next_endFlag = 1'b0;
      end
    end
    if (abortNow) begin
      next_busy = 1'b0;
    end
    if (wrPrimary) begin
      next_startBit  = hwdata[adc_ctrl_pkg::BIT_START];
      next_opMode    = hwdata[adc_ctrl_pkg::BIT_MODE_HI:
                              adc_ctrl_pkg::BIT_MODE_LO];
      next_inputGate = hwdata[adc_ctrl_pkg::BIT_GATE];
      next_channel   = hwdata[3:0];
    end
    if (wrStatus) begin
      next_resultWidth = hwdata[adc_ctrl_pkg::BIT_WIDTH];
      next_deepIdleCtl = hwdata[adc_ctrl_pkg::BIT_DEEP_IDLE];
      next_convTime    = hwdata[3:0];
    end
    if (lowPower) begin
      next_startBit    = 1'b0;
      next_opMode      = adc_ctrl_pkg::MODE_OFF;
      next_inputGate   = 1'b0;
      next_resultWidth = 1'b0;
      next_endFlag     = 1'b0;
      next_busy        = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      startBit    <= 1'b0;
      opMode      <= adc_ctrl_pkg::MODE_OFF;
      inputGate   <= 1'b0;
      channel     <= 4'h0;
      resultWidth <= 1'b0;
      deepIdleCtl <= 1'b0;
      convTime    <= adc_ctrl_pkg::TIME_RESET;
      endFlag     <= 1'b0;
      busy        <= 1'b0;
      resUpper    <= 8'h00;
      resLower    <= 8'h00;
      irq         <= 1'b0;
      startPulse  <= 1'b0;
    end else begin
      startBit    <= next_startBit;
      opMode      <= next_opMode;
      inputGate   <= next_inputGate;
      channel     <= next_channel;
      resultWidth <= next_resultWidth;
      deepIdleCtl <= next_deepIdleCtl;
      convTime    <= next_convTime;
      endFlag     <= next_endFlag;
      busy        <= next_busy;
      resUpper    <= next_resUpper;
      resLower    <= next_resLower;
      irq         <= next_irq;
      startPulse  <= next_startPulse;
    end
  end

  assign analogChannel     = channel;
  assign analogInputEnable = inputGate;
  assign convRunning       = busy;
  assign convStart         = startPulse;
  assign convDoneIrq       = irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_completion;
    done ##1 (endFlag && convDoneIrq);
  endsequence

  property p_start_selfclear;
    launch && !busy |=> !startBit && busy && convStart;
  endproperty
  a_start_selfclear: assert property (p_start_selfclear)
    else $error("start bit did not launch and clear");

  property p_busy_at_start;
    $rose(busy) |-> !endFlag && convStart;
  endproperty
  a_busy_at_start: assert property (p_busy_at_start)
    else $error("busy rose without start or with end flag");

  property p_upper_read_clears;
    readUpperHit && !done |=> !endFlag;
  endproperty
  a_upper_read_clears: assert property (p_upper_read_clears)
    else $error("upper result read left end flag set");

  property p_done_reports;
    done |-> s_completion;
  endproperty
  a_done_reports: assert property (p_done_reports)
    else $error("completion did not set end flag and interrupt");

  property p_repeat_restarts;
    done && opMode == adc_ctrl_pkg::MODE_REPEAT |=> busy && convStart;
  endproperty
  a_repeat_restarts: assert property (p_repeat_restarts)
    else $error("repeat mode did not restart");

  property p_mode_off_aborts;
    wrPrimary && hwdata[6:5] == adc_ctrl_pkg::MODE_OFF
      |=> !busy && $stable(resUpper) && $stable(resLower);
  endproperty
  a_mode_off_aborts: assert property (p_mode_off_aborts)
    else $error("mode off did not abort cleanly");

  property p_low_power_primary;
    lowPower |=> opMode == adc_ctrl_pkg::MODE_OFF && !inputGate
      && channel == $past(channel) && convTime == $past(convTime);
  endproperty
  a_low_power_primary: assert property (p_low_power_primary)
    else $error("low-power entry mishandled control fields");

  property p_ten_bit_upper;
    done && !resultWidth |=> resUpper[7:2] == 6'h00
      && resUpper[1:0] == $past(convResult[9:8]);
  endproperty
  a_ten_bit_upper: assert property (p_ten_bit_upper)
    else $error("ten-bit upper result has stray bits");

  property p_time_78;
    launch && !busy && convTime == adc_ctrl_pkg::TIME_78
      |=> (busy && !done)[*8] ##70 (!busy || done);
  endproperty
  a_time_78: assert property (p_time_78)
    else $error("78-cycle conversion length wrong");

  // the only short code legal at this clock rate
  property p_time_312;
    launch && !busy && convTime == adc_ctrl_pkg::TIME_312
      |=> (busy && !done)[*8] ##300 (busy && !done) ##4 done;
  endproperty
  a_time_312: assert property (p_time_312)
    else $error("312-cycle conversion length wrong");
endmodule
`default_nettype wire

// [bench/analog_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
  input  wire logic       clk,
  input  wire logic       convStart,
  input  wire logic       convRunning,
  input  wire logic [3:0] analogChannel,
  input  wire logic [5:0] level,
  output logic      [9:0] convResult
);
  logic [9:0] held = 10'h000;
  always_ff @(posedge clk) begin
    if (convStart) begin
      held <= {analogChannel, level};
    end
  end
  // stale outside a conversion: show the inverse, never the last value
  assign convResult = convRunning ? held : ~held;
endmodule
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [31:0] A_PRI = {20'h0, adc_ctrl_pkg::IDX_PRIMARY, 2'h0};
  localparam logic [31:0] A_STA = {20'h0, adc_ctrl_pkg::IDX_STATUS, 2'h0};
  localparam logic [31:0] A_LO = {20'h0, adc_ctrl_pkg::IDX_RESULT_LOWER, 2'h0};
  localparam logic [31:0] A_HI = {20'h0, adc_ctrl_pkg::IDX_RESULT_UPPER, 2'h0};
  logic        clk = 1'b0;
  logic        sysRst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  lowPower = 3'h0;
  logic        inDeepIdle = 1'b0;
  logic [5:0]  level = 6'h00;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [9:0]  convResult;
  logic [3:0]  analogChannel;
  logic        analogInputEnable;
  logic        convRunning;
  logic        convStart;
  logic        convDoneIrq;
  logic [9:0]  r;
  time         t0;
  int          errors = 0;
  int          compares = 0;

  initial forever #25 clk = ~clk;

  adc_control_registers u_adc_control_registers (
    .clk(clk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .enterStop(lowPower[0]), .enterSlow(lowPower[1]),
    .enterLightIdle(lowPower[2]), .inDeepIdle(inDeepIdle),
    .convResult(convResult), .analogChannel(analogChannel),
    .analogInputEnable(analogInputEnable), .convRunning(convRunning),
    .convStart(convStart), .convDoneIrq(convDoneIrq)
  );
  analog_core_model u_analog_core_model (
    .clk(clk), .convStart(convStart), .convRunning(convRunning),
    .analogChannel(analogChannel), .level(level), .convResult(convResult)
  );

  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang();
    errors++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  endtask
  // address phase held until hready, then data phase held until hready
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    logic ok;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin
        @(negedge clk);
        ok = hreadyout;
        q = hrdata;
        if (i == 1) chk(32'(hresp), 32'h0);
        @(posedge clk);
        n++;
      end while (ok !== 1'b1 && n < 50);
      if (ok !== 1'b1) hang();
      if (i == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  function automatic int cycles_of(input logic [3:0] code);
    case (code)
      4'hA: return int'(adc_ctrl_pkg::CYC_78);
      4'hB: return int'(adc_ctrl_pkg::CYC_156);
      4'hC: return int'(adc_ctrl_pkg::CYC_312);
      4'hD: return int'(adc_ctrl_pkg::CYC_624);
      default: return int'(adc_ctrl_pkg::CYC_1248);
    endcase
  endfunction
  // start-write edge to visible pulse is n plus a cycle or two
  task automatic wait_irq(input int n);
    int c;
    c = 0;
    do begin
      @(negedge clk);
      if (++c > 2000) hang();
    end while (convDoneIrq !== 1'b1);
    c = int'(($time - t0) / 50);
    chk(32'(c >= n - 2 && c <= n + 3), 32'h1);
    @(posedge clk);
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      chk(32'(convDoneIrq), 32'h0);
    end
  endtask
  task automatic start(input logic [7:0] sta, input logic [7:0] pri);
    logic [5:0] lv;
    @(posedge clk);
    lv = 6'($urandom);
    level <= lv;
    r = {pri[3:0], lv};
    wr(A_STA, {24'h0, sta});
    wr(A_PRI, {24'h0, pri});
    t0 = $time;
  endtask
  task automatic conv(input logic [3:0] code, input logic w8);
    logic [3:0] ch;
    ch = 4'($urandom);
    start({2'h0, w8, 1'b0, code}, {4'hB, ch});
    @(negedge clk);
    chk(32'(analogChannel), 32'(ch));
    chk(32'(analogInputEnable), 32'h1);
    rdc(A_PRI, {24'h0, 4'h3, ch});
    rdc(A_STA, {24'h0, 2'h1, w8, 1'b0, code});
    wait_irq(cycles_of(code));
    rdc(A_STA, {24'h0, 2'h2, w8, 1'b0, code});
    rdc(A_LO, {24'h0, r[7:0]});
    rdc(A_HI, w8 ? {24'h0, r[9:2]} : {30'h0, r[9:8]});
    rdc(A_STA, {24'h0, 2'h0, w8, 1'b0, code});
    $display("test conv code %h done", code);
  endtask

  initial begin
    void'($urandom(57));
    repeat (6) @(posedge clk);
    sysRst <= 1'b0;
    rdc(A_PRI, 32'h0);
    rdc(A_STA, 32'h0C);
    rdc(32'hAD0, 32'h0);
    $display("test reset done");
    // only codes legal at this clock and at least 15.6 us
    for (int c = 12; c <= 14; c++) conv(4'(c), 1'(c));
    wr(A_PRI, 32'hC0);
    repeat (3) @(negedge clk);
    chk(32'(convRunning), 32'h0);
    start(8'h0C, 8'hE5);
    wait_irq(312);
    t0 = $time;
    level <= ~r[5:0];
    wait_irq(312);
    rdc(A_LO, {24'h0, r[7:0]});
    repeat (40) @(posedge clk);
    wr(A_PRI, 32'h05);
    @(negedge clk);
    chk(32'(convRunning), 32'h0);
    quiet(400);
    rdc(A_LO, {24'h0, r[7:0]});
    $display("test repeat and abort done");
    for (int k = 0; k < 3; k++) begin
      start(8'h3D, 8'hB9);
      repeat (5) @(posedge clk);
      lowPower[k] <= 1'b1;
      @(posedge clk);
      lowPower <= 3'h0;
      @(negedge clk);
      chk(32'(convRunning), 32'h0);
      rdc(A_PRI, 32'h09);
      rdc(A_STA, 32'h1D);
      quiet(100);
    end
    $display("test low power done");
    start(8'h0C, 8'hA1);
    inDeepIdle <= 1'b1;
    repeat (3) @(negedge clk);
    chk(32'(convRunning), 32'h0);
    @(posedge clk);
    inDeepIdle <= 1'b0;
    wr(A_STA, 32'hDC);
    rdc(A_STA, 32'h1C);
    inDeepIdle <= 1'b1;
    start(8'h1C, 8'hA2);
    wait_irq(312);
    inDeepIdle <= 1'b0;
    $display("test deep idle done");
    close_out();
  end
endmodule
`default_nettype wire
